// ### hw/opb_pkg.sv
package opb_pkg;
    // ========================================================
    // Register map, byte addresses
    localparam logic [7:0] ADDR_DATA   = 8'h00;
    localparam logic [7:0] ADDR_MODE   = 8'h04;
    localparam logic [7:0] ADDR_CMDST  = 8'h08;
    localparam logic [7:0] ADDR_INDATA = 8'h0c;
    localparam logic [7:0] ADDR_PAT    = 8'h10;
    localparam logic [7:0] ADDR_MASK   = 8'h14;

    // ========================================================
    // Mode register fields
    localparam int MODE_SB   = 0;
    localparam int MODE_ITB  = 1;
    localparam int MODE_PMLO = 2;
    localparam int MODE_PMHI = 3;
    localparam int MODE_EN   = 4;
    localparam int MODE_IE   = 5;

    // ========================================================
    // Command and status fields
    localparam int CS_IP    = 0;
    localparam int CS_ORE   = 1;
    localparam int CS_PMF   = 2;
    localparam int CS_IRF   = 3;
    localparam int CS_BFULL = 4;
    localparam int CS_CLRIP = 5;

    // ========================================================
    // Match modes on {hi, lo}
    localparam logic [1:0] PM_OFF = 2'h0;
    localparam logic [1:0] PM_AND = 2'h1;
    localparam logic [1:0] PM_OR  = 2'h2;

    localparam logic [31:0] RST_WORD = 32'h0000_0000;
endpackage : opb_pkg

// ### hw/opb_edge.sv
`timescale 1ns/1ps
module opb_edge (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Level in, falling pulse out
    input  wire logic level_in,
    output logic      fall_pulse
);
    // ========================================================
    // Falling edge detect
    // Idle level high so no event right after reset
    typedef struct packed {
        logic prev;
    } opb_edge_t;

    opb_edge_t s_q;
    opb_edge_t s_d;

    always_comb begin
        s_d      = s_q;
        s_d.prev = level_in;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{prev: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    assign fall_pulse = s_q.prev & ~level_in;
endmodule : opb_edge

// ### hw/opb_match.sv
`timescale 1ns/1ps
module opb_match #(
    parameter int WIDTH = 8
) (
    // Byte under test
    input  wire logic [WIDTH-1:0] data,
    input  wire logic [WIDTH-1:0] pattern,
    input  wire logic [WIDTH-1:0] mask,
    input  wire logic [1:0]       mode,
    // Result
    output logic                  hit
);
    // ========================================================
    // Masked compare
    logic [WIDTH-1:0] eq;

    assign eq = ~(data ^ pattern) & mask;

    // AND and OR only
    // No transition mode: history of the pins is not kept here
    always_comb begin
        if (mode == opb_pkg::PM_AND) begin
            hit = (eq == mask);
        end else if (mode == opb_pkg::PM_OR) begin
            hit = |eq;
        end else begin
            hit = 1'b0;
        end
    end
endmodule : opb_match

// ### hw/opb_port.sv
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module opb_port #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // APB slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    // Port pins
    output logic      [WIDTH-1:0] port_data,
    output logic                  data_valid_strobe_n,
    input  wire logic             ack_input,
    // Request
    output logic                  port_irq
);
    // ========================================================
    // State
    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_ACK
    } opb_bus_t;

    typedef struct packed {
        opb_bus_t         bus;
        logic [31:0]      rdata;
        logic             slverr;
        logic             ready;
        logic [WIDTH-1:0] odr;
        logic [WIDTH-1:0] buf_r;
        logic [WIDTH-1:0] pat;
        logic [WIDTH-1:0] msk;
        logic             odr_full;
        logic             buf_full;
        logic             latched;
        logic             ip;
        logic             match_flag;
        logic             sb;
        logic             two_byte_interrupt;
        logic [1:0]       pms;
        logic             en;
        logic             ie;
        logic             dav_n;
        logic             irq;
    } opb_state_t;

    opb_state_t s_q;
    opb_state_t s_d;

    logic ack_fall;
    logic hit;

    // ========================================================
    // Leaf blocks
    opb_edge u_edge (
        .pclk       (pclk),
        .presetn    (presetn),
        .level_in   (ack_input),
        .fall_pulse (ack_fall)
    );

    opb_match #(.WIDTH(WIDTH)) u_match (
        .data    (s_q.odr),
        .pattern (s_q.pat),
        .mask    (s_q.msk),
        .mode    (s_q.pms),
        .hit     (hit)
    );

    // ========================================================
    // Next state
    logic acc;
    logic wr;
    logic rd;
    logic wr_data;
    logic cmd_clr;
    logic move;
    logic ack_now;
    logic [31:0] rv;

    always_comb begin
        s_d     = s_q;
        acc     = psel & penable & (s_q.bus == BUS_IDLE);
        wr      = acc & pwrite;
        rd      = acc & ~pwrite;
        wr_data = wr && (paddr == opb_pkg::ADDR_DATA);
        cmd_clr = wr && (paddr == opb_pkg::ADDR_CMDST)
                  && pwdata[opb_pkg::CS_CLRIP];
        rv      = opb_pkg::RST_WORD;

        // Bus answers one cycle after the access phase opens
        if (s_q.bus == BUS_ACK) begin
            s_d.bus = BUS_IDLE;
        end else if (acc) begin
            s_d.bus = BUS_ACK;
        end
        // Registered so the ready pin comes from a flop
        s_d.ready = (s_d.bus == BUS_ACK);

        ack_now = ack_fall & s_q.en & s_q.buf_full;
        if (ack_now) begin
            s_d.buf_full = 1'b0;
            if (s_q.sb) begin
                s_d.odr_full = 1'b0;
                s_d.ip       = 1'b1;
            end else if (s_q.two_byte_interrupt && !s_q.odr_full) begin
                s_d.ip = 1'b1;
            end
        end

        move = s_q.en & s_q.odr_full & ~s_q.buf_full;
        if (move) begin
            s_d.buf_r    = s_q.odr;
            s_d.buf_full = 1'b1;
            s_d.match_flag      = hit;
            if (!s_q.sb) begin
                s_d.odr_full = 1'b0;
                if (!s_q.two_byte_interrupt) begin
                    s_d.ip = 1'b1;
                end
            end
            if (hit) begin
                s_d.ip = 1'b1;
            end
        end

        if (cmd_clr && !move && !ack_now) begin
            s_d.ip = 1'b0;
        end

        if (wr_data) begin
            s_d.odr = pwdata[WIDTH-1:0];
            if (s_q.match_flag && s_q.ip && !cmd_clr) begin
                s_d.latched = 1'b1;
            end else begin
                s_d.odr_full = 1'b1;
                s_d.latched  = 1'b0;
                if (!move && !ack_now) begin
                    s_d.ip = 1'b0;
                end
            end
        end else if (cmd_clr && s_q.latched) begin
            s_d.odr_full = 1'b1;
            s_d.latched  = 1'b0;
        end

        // Configuration
        if (wr && (paddr == opb_pkg::ADDR_MODE)) begin
            s_d.sb  = pwdata[opb_pkg::MODE_SB];
            s_d.two_byte_interrupt = pwdata[opb_pkg::MODE_ITB]
                      & ~pwdata[opb_pkg::MODE_SB];
            s_d.pms = {pwdata[opb_pkg::MODE_PMHI],
                       pwdata[opb_pkg::MODE_PMLO]};
            if (s_d.pms == 2'h3) begin
                s_d.pms = opb_pkg::PM_OFF;
            end
            s_d.en  = pwdata[opb_pkg::MODE_EN];
            s_d.ie  = pwdata[opb_pkg::MODE_IE];
        end
        if (wr && (paddr == opb_pkg::ADDR_PAT)) begin
            s_d.pat = pwdata[WIDTH-1:0];
        end
        if (wr && (paddr == opb_pkg::ADDR_MASK)) begin
            s_d.msk = pwdata[WIDTH-1:0];
        end

        // Read decode
        s_d.slverr = 1'b0;
        if (paddr == opb_pkg::ADDR_DATA) begin
            rv[WIDTH-1:0] = s_q.odr;
        end else if (paddr == opb_pkg::ADDR_MODE) begin
            rv[opb_pkg::MODE_SB]   = s_q.sb;
            rv[opb_pkg::MODE_ITB]  = s_q.two_byte_interrupt;
            rv[opb_pkg::MODE_PMLO] = s_q.pms[0];
            rv[opb_pkg::MODE_PMHI] = s_q.pms[1];
            rv[opb_pkg::MODE_EN]   = s_q.en;
            rv[opb_pkg::MODE_IE]   = s_q.ie;
        end else if (paddr == opb_pkg::ADDR_CMDST) begin
            rv[opb_pkg::CS_IP]    = s_q.ip;
            rv[opb_pkg::CS_ORE]   = ~s_q.odr_full;
            rv[opb_pkg::CS_PMF]   = s_q.match_flag;
            rv[opb_pkg::CS_IRF]   = 1'b0;
            rv[opb_pkg::CS_BFULL] = s_q.buf_full;
        end else if (paddr == opb_pkg::ADDR_INDATA) begin
            rv[WIDTH-1:0] = s_q.buf_r;
        end else if (paddr == opb_pkg::ADDR_PAT) begin
            rv[WIDTH-1:0] = s_q.pat;
        end else if (paddr == opb_pkg::ADDR_MASK) begin
            rv[WIDTH-1:0] = s_q.msk;
        end else if (acc) begin
            s_d.slverr = 1'b1;
        end
        if (rd) begin
            s_d.rdata = rv;
        end
        if (!acc) begin
            s_d.slverr = 1'b0;
        end

        // strobe low while valid
        // Strobed style: ack not interlocked here
        s_d.dav_n = ~(s_d.buf_full & s_d.en);
        s_d.irq   = s_d.ip & s_d.ie;
    end

    // ========================================================
    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q          <= '0;
            s_q.bus      <= BUS_IDLE;
            s_q.dav_n    <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata              = s_q.rdata;
    assign pready              = s_q.ready;
    assign pslverr             = s_q.slverr;
    assign port_data           = s_q.buf_r;
    assign data_valid_strobe_n = s_q.dav_n;
    assign port_irq            = s_q.irq;
endmodule : opb_port

// ### bench/opb_port_asserts.sv
`timescale 1ns/1ps
module opb_port_asserts #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input logic             pclk,
    input logic             presetn,
    // APB
    input logic             psel,
    input logic             penable,
    input logic             pwrite,
    input logic [7:0]       paddr,
    input logic [31:0]      prdata,
    input logic             pready,
    input logic             pslverr,
    // Port pins
    input logic [WIDTH-1:0] port_data,
    input logic             data_valid_strobe_n,
    input logic             ack_input,
    input logic             port_irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========
    // Bus and port checks
    chk_ready_once: assert property (pready |=> !pready)
        else $error("ready too long");
    chk_ready_late: assert property (psel && penable && !pready |=> pready)
        else $error("ready late");
    chk_err_map: assert property (pready |-> pslverr ==
        !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14}))
        else $error("bad error flag");
    chk_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 0)
        else $error("refused read not zero");
    chk_irf_zero: assert property (
        pready && !pwrite && paddr == 8'h08 |-> !prdata[opb_pkg::CS_IRF])
        else $error("input full flag set");
    chk_buf_read: assert property (
        pready && !pwrite && paddr == 8'h0c |-> prdata[WIDTH-1:0] == port_data
        || prdata[WIDTH-1:0] == $past(port_data))
        else $error("buffer read wrong");
    chk_strobe_drop: assert property (
        $fell(ack_input) && !data_valid_strobe_n |-> ##[1:4] data_valid_strobe_n)
        else $error("ack did not empty buffer");
    chk_data_hold: assert property (
        !data_valid_strobe_n && !$past(data_valid_strobe_n)
        |-> $stable(port_data))
        else $error("data moved under strobe");
    chk_irq_clear: assert property (
        $fell(port_irq) |-> $past(pwrite) && $past(psel))
        else $error("request dropped unprompted");
endmodule : opb_port_asserts

// ### bench/opb_rx_model.sv
`timescale 1ns/1ps
module opb_rx_model (
    // Clock and reset
    input  logic       pclk,
    input  logic       presetn,
    // Port pins
    input  logic [7:0] port_data,
    input  logic       data_valid_strobe_n,
    output logic       ack_input,
    // Bench control
    input  logic       go,
    input  logic [3:0] wait_cyc,
    output logic [7:0] got_byte
);
    logic [3:0] cnt_q;
    logic       armed_q;
    // ==========
    // Receiver, one ack per strobe so a byte is never taken twice
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_input <= 1'b1;
            cnt_q     <= 4'h0;
            armed_q   <= 1'b1;
            got_byte  <= 8'h00;
        end else if (!ack_input) begin
            ack_input <= 1'b1;
        end else if (data_valid_strobe_n) begin
            armed_q <= 1'b1;
        end else if (go && armed_q) begin
            if (cnt_q == wait_cyc) begin
                ack_input <= 1'b0;
                got_byte  <= port_data;
                cnt_q     <= 4'h0;
                armed_q   <= 1'b0;
            end else begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end
endmodule : opb_rx_model

// ### bench/output_port_buffer_intr_tb_top.sv
`timescale 1ns/1ps
module output_port_buffer_intr_tb_top;
    logic        pclk;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  port_data;
    logic        data_valid_strobe_n;
    logic        ack_input;
    logic        port_irq;
    logic        rx_go   = 1'b0;
    logic [3:0]  rx_wait = 4'h0;
    logic [7:0]  rx_byte;
    logic [31:0] rd;
    logic        err;
    logic [27:0] r;
    int          mismatches = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    // ==========
    // Rows: op, address, data or expected, mask; op 2 releases a byte
    // two byte mode never set with single buffer
    // status polled before clear and write
    logic [27:0] rows [48] = '{
    28'h0040000, 28'h000a500, 28'h108001f, 28'h0043000, 28'h108131f,
    28'h10ca5ff, 28'h0003c00, 28'h108101f, 28'h200a500, 28'h108131f,
    28'h0082000, 28'h108121f, 28'h2003c00, 28'h108021f, 28'h0043200,
    28'h0001100, 28'h108121f, 28'h0002200, 28'h108101f, 28'h2001100,
    28'h108121f, 28'h2002200, 28'h108031f, 28'h0043100, 28'h0004400,
    28'h108101f, 28'h10044ff, 28'h2004400, 28'h108031f, 28'h0105500,
    28'h014ff00, 28'h0043400, 28'h0005500, 28'h108171f, 28'h0006600,
    28'h108171f, 28'h0082000, 28'h108141f, 28'h2005500, 28'h108131f,
    28'h0043800, 28'h0140f00, 28'h000fa00, 28'h2006600, 28'h108131f,
    28'h0000f00, 28'h200fa00, 28'h108171f};

    opb_port i_opb_port (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .port_data(port_data), .data_valid_strobe_n(data_valid_strobe_n),
        .ack_input(ack_input), .port_irq(port_irq));
    opb_rx_model i_opb_rx_model (.pclk(pclk), .presetn(presetn),
        .port_data(port_data), .data_valid_strobe_n(data_valid_strobe_n),
        .ack_input(ack_input), .go(rx_go), .wait_cyc(rx_wait),
        .got_byte(rx_byte));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task automatic stop_test();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // Varying wait gives prompt and slow receivers
    task automatic rel(input logic [7:0] e);
        rx_go <= 1'b1;
        while (ack_input !== 1'b0) @(posedge pclk);
        rx_go   <= 1'b0;
        rx_wait <= rx_wait + 4'h5;
        repeat (6) @(posedge pclk);
        cmp({24'h0, rx_byte}, {24'h0, e});
    endtask : rel

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (rows[i]) begin
            r = rows[i];
            if (r[27:24] == 4'h0) apb(1'b1, r[23:16], {24'h0, r[15:8]});
            else if (r[27:24] == 4'h2) rel(r[15:8]);
            else begin
                apb(1'b0, r[23:16], 32'h0);
                cmp(rd & {24'h0, r[7:0]}, {24'h0, r[15:8]});
                if (r[23:16] == 8'h08)
                    cmp({31'h0, port_irq}, {31'h0, r[8]});
            end
        end
        // Undefined match code must read back as off
        apb(1'b1, 8'h04, 32'h0000_003c);
        apb(1'b0, 8'h04, 32'h0);
        cmp(rd & 32'h3f, 32'h30);
        // Refused address, then reset while the buffer is full
        apb(1'b0, 8'h18, 32'h0);
        cmp({31'h0, err}, 32'h1);
        cmp(rd, 32'h0);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        cmp({22'h0, data_valid_strobe_n, port_irq, port_data}, 32'h200);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 8'h08, 32'h0);
        cmp(rd & 32'h1, 32'h0);
        stop_test();
    end

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            stop_test();
        end
    end
endmodule : output_port_buffer_intr_tb_top

bind opb_port opb_port_asserts #(.WIDTH(WIDTH)) i_opb_port_asserts (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_data(port_data), .ack_input(ack_input),
    .data_valid_strobe_n(data_valid_strobe_n), .port_irq(port_irq));
